/* bench/fifo_256x18_flags_test.sv */
// Self-checking bench: pins through the link model, registers over APB.
// Assumes fifo_pkg, fifo_buf_top and fifo_link_model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
   $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end

module fifo_256x18_flags_test
   import fifo_pkg::*;
;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic fifo_rst_n = 1'b1;
   logic output_enable_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er;
   logic [17:0] data_in_bus, data_out_bus;
   logic write_strobe_in, read_strobe_in, offset_program_enable_n, data_out_drive;
   logic full_flag_n, empty_flag_n, half_level_flag, edge_level_flag;
   wire logic [17:0] q_pin;
   int err_total = 0;
   int samples_checked = 0;
   int cnt = 0;

   always #10 clk = ~clk;
   assign q_pin = data_out_drive ? data_out_bus : {18{1'bz}};

   fifo_link_model i_fifo_link_model (.clk(clk), .data_in_bus(data_in_bus),
      .write_strobe_in(write_strobe_in), .read_strobe_in(read_strobe_in),
      .offset_program_enable_n(offset_program_enable_n));

   fifo_buf_top i_fifo_buf_top (.clk(clk), .sys_rst(sys_rst), .data_in_bus(data_in_bus),
      .write_strobe_in(write_strobe_in), .read_strobe_in(read_strobe_in),
      .offset_program_enable_n(offset_program_enable_n), .fifo_rst_n(fifo_rst_n),
      .output_enable_n(output_enable_n), .data_out_bus(data_out_bus),
      .data_out_drive(data_out_drive), .full_flag_n(full_flag_n),
      .empty_flag_n(empty_flag_n), .half_level_flag(half_level_flag),
      .edge_level_flag(edge_level_flag), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   function automatic fifo_flags_t exp_flags(input int c, input int x, input int y);
      fifo_flags_t f;
      f.edge_lvl = (c <= x) || (c >= 256 - y);
      f.half = (c >= 128);
      f.empty_n = (c != 0);
      f.full_n = (c != 256);
      return f;
   endfunction

   task automatic flags(input int x, input int y);
      repeat (3) @(posedge clk);
      `CHK({edge_level_flag, half_level_flag, empty_flag_n, full_flag_n}, exp_flags(cnt, x, y))
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Pin reset is synchronised inside, so it is held well past the two flops
   task automatic dev_reset;
      @(posedge clk);
      fifo_rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      fifo_rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      cnt = 0;
   endtask

   task final_report;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      #1_000_000;
      err_total++;
      final_report();
   end

   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      dev_reset();
      flags(32, 32);
      apb(1'b0, 12'h008, '0);
      `CHK(rd, 32'h00002020)
      for (int i = 0; i < 256; i++) begin
         i_fifo_link_model.pulse(1'b1, 1'b0, 18'h20000 | 18'(i), 1'b1, 0);
         cnt++;
         flags(32, 32);
         if (i == 0) `CHK(q_pin, 18'h20000)
      end
      i_fifo_link_model.pulse(1'b1, 1'b0, 18'h3FFFF, 1'b1, 0);
      flags(32, 32);
      apb(1'b0, 12'h000, '0);
      `CHK(rd, 32'h002E0100)
      output_enable_n <= 1'b1;
      repeat (4) @(posedge clk);
      `CHK(q_pin, {18{1'bz}})
      output_enable_n <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 256; i++) begin
         `CHK(q_pin, 18'h20000 | 18'(i))
         i_fifo_link_model.pulse(1'b0, 1'b1, '0, 1'b1, 0);
         cnt--;
         flags(32, 32);
      end
      i_fifo_link_model.pulse(1'b0, 1'b1, '0, 1'b1, 3);
      flags(32, 32);
      dev_reset();
      i_fifo_link_model.pulse(1'b1, 1'b0, 18'h3FF85, 1'b0, 0);
      i_fifo_link_model.pulse(1'b1, 1'b0, 18'h0007F, 1'b0, 0);
      apb(1'b0, 12'h008, '0);
      `CHK(rd, 32'h00007F05)
      apb(1'b0, 12'h000, '0);
      `CHK(rd, 32'h00290000)
      for (int i = 1; i < 8; i++) begin
         i_fifo_link_model.pulse(1'b1, 1'b0, 18'(i), 1'b1, 0);
         cnt++;
         flags(5, 127);
      end
      i_fifo_link_model.pulse(1'b1, 1'b1, 18'h00008, 1'b1, 0);
      flags(5, 127);
      `CHK(q_pin, 18'h00002)
      apb(1'b1, 12'h004, 32'h00000001);
      repeat (4) @(posedge clk);
      cnt = 0;
      flags(32, 32);
      apb(1'b0, 12'h00C, '0);
      `CHK(er, 1'b1)
      `CHK(rd, 32'h00000000)
      final_report();
   end
endmodule // fifo_256x18_flags_test

`default_nettype wire

/* bench/fifo_link_model.sv */
// Writer and reader systems on the far side of the strobe pins.
// Assumes the caller waits for all resets to settle before the first pulse.
`timescale 1ns/100ps
`default_nettype none

module fifo_link_model (
   input wire logic clk,
   output logic [17:0] data_in_bus,
   output logic write_strobe_in,
   output logic read_strobe_in,
   output logic offset_program_enable_n
);
   initial begin
      data_in_bus = '0;
      write_strobe_in = 1'b0;
      read_strobe_in = 1'b0;
      offset_program_enable_n = 1'b1;
   end

   // One strobe period of 160 ns; lag stretches the low phase for a slow partner
   task automatic pulse(input logic w, input logic r, input logic [17:0] d,
                        input logic prog_n, input int lag);
      @(posedge clk);
      data_in_bus <= d;
      offset_program_enable_n <= prog_n;
      repeat (3 + lag) @(posedge clk);
      write_strobe_in <= w;
      read_strobe_in <= r;
      repeat (4) @(posedge clk);
      write_strobe_in <= 1'b0;
      read_strobe_in <= 1'b0;
      // Stale data is inverted so a late sample cannot pass by luck
      data_in_bus <= ~d;
   endtask
endmodule // fifo_link_model

`default_nettype wire

/* verilog/fifo_buf_top.sv */
// Strobed 256 x 18 buffer with full, empty, half and programmable edge flags.
// Assumes data, strobe, program, fifo_rst_n and enable pins are asynchronous to clk and change far slower than 50 MHz;
// APB master on clk.
`timescale 1ns/100ps
`default_nettype none
`include "fifo_regs.svh"

module fifo_buf_top
   import fifo_pkg::*;
#(
   parameter int DEPTH = `FIFO_DEPTH,
   parameter int WIDTH = `FIFO_WIDTH
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] data_in_bus,
   input wire logic write_strobe_in,
   input wire logic read_strobe_in,
   input wire logic offset_program_enable_n,
   input wire logic fifo_rst_n,
   input wire logic output_enable_n,
   output logic [WIDTH-1:0] data_out_bus,
   output logic data_out_drive,
   output logic full_flag_n,
   output logic empty_flag_n,
   output logic half_level_flag,
   output logic edge_level_flag,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   localparam int AW = $clog2(DEPTH);
   localparam int OW = `FIFO_OFS_W;
   localparam int SW = WIDTH + 5;
   localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
   localparam logic [AW:0] HALF_CNT = (AW+1)'(DEPTH / 2);

   function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
      logic [AW:0] b;
      b[AW] = g[AW];
      for (int i = AW - 1; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   // Two-stage synchroniser; data travels with its strobe so both line up
   logic [SW-1:0] sync_a;
   logic [SW-1:0] sync_b;
   always_ff @(posedge clk) begin
      sync_a <= {data_in_bus, write_strobe_in, read_strobe_in,
                 offset_program_enable_n, fifo_rst_n, output_enable_n};
      sync_b <= sync_a;
   end

   fifo_pins_t pins_s;
   logic [WIDTH-1:0] din_s;
   assign pins_s = fifo_pins_t'(sync_b[4:0]);
   assign din_s = sync_b[SW-1:5];

   // Previous levels start high so a strobe held high at reset is no edge
   logic wr_prev;
   logic rd_prev;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_prev <= 1'b1;
         rd_prev <= 1'b1;
      end else begin
         wr_prev <= pins_s.wr;
         rd_prev <= pins_s.rd;
      end
   end

   logic wr_edge;
   logic rd_edge;
   assign wr_edge = pins_s.wr & ~wr_prev;
   assign rd_edge = pins_s.rd & ~rd_prev;

   logic flush;
   logic clear;
   assign clear = sys_rst | ~pins_s.rst_n | flush;

   // Pointers live in Gray code; counts come from their binary images
   logic [AW:0] wr_gray;
   logic [AW:0] rd_gray;
   logic [AW:0] wr_bin;
   logic [AW:0] rd_bin;
   logic [AW:0] count;
   logic full;
   logic empty;
   assign wr_bin = gray2bin(wr_gray);
   assign rd_bin = gray2bin(rd_gray);
   assign count = wr_bin - rd_bin;
   assign full = (count == DEPTH_CNT);
   assign empty = (count == '0);

   fifo_state_t state;
   logic [OW-1:0] ofs_x;
   logic [OW-1:0] ofs_y;
   logic do_write;
   logic do_read;

   // Program enable is active low; any edge before the run state may load
   logic prog_low;
   assign prog_low = ~pins_s.prog_n;
   logic prog_edge;
   assign prog_edge = wr_edge & prog_low & (state != fifo_run);
   // Status and full are judged before this cycle's edges, so coincident
   // strobes on a full or empty buffer still move only one pointer
   assign do_write = wr_edge & ~full & ~prog_edge;
   assign do_read = rd_edge & ~empty;

   always_ff @(posedge clk) begin
      if (clear) begin
         wr_gray <= '0;
      end else if (do_write) begin
         wr_gray <= bin2gray(wr_bin + (AW+1)'(1));
      end
   end

   always_ff @(posedge clk) begin
      if (clear) begin
         rd_gray <= '0;
      end else if (do_read) begin
         rd_gray <= bin2gray(rd_bin + (AW+1)'(1));
      end
   end

   // Offset programming window closes at the first plain data write or at the second program edge
   always_ff @(posedge clk) begin
      if (clear) begin
         state <= fifo_prog_x;
         ofs_x <= `FIFO_OFS_DEFAULT;
         ofs_y <= `FIFO_OFS_DEFAULT;
      end else if (wr_edge) begin
         unique case (state)
            fifo_prog_x: begin
               if (prog_low) begin
                  ofs_x <= din_s[OW-1:0];
                  ofs_y <= din_s[OW-1:0];
                  state <= fifo_prog_y;
               end else begin
                  state <= fifo_run;
               end
            end
            fifo_prog_y: begin
               if (prog_low) begin
                  ofs_y <= din_s[OW-1:0];
               end
               state <= fifo_run;
            end
            fifo_run: begin
               state <= fifo_run;
            end
            // Unused code: resume normal writes rather than lock them out
            default: begin
               state <= fifo_run;
            end
         endcase
      end
   end

   logic [WIDTH-1:0] mem [DEPTH];
   always_ff @(posedge clk) begin
      if (do_write) begin
         mem[wr_bin[AW-1:0]] <= din_s;
      end
   end

   // Head word is always shown, so the first word needs no read strobe
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         data_out_bus <= '0;
         data_out_drive <= 1'b0;
      end else begin
         data_out_bus <= mem[rd_bin[AW-1:0]];
         data_out_drive <= ~pins_s.oe_n;
      end
   end

   logic edge_now;
   assign edge_now = (count <= (AW+1)'(ofs_x)) |
                     (count >= DEPTH_CNT - (AW+1)'(ofs_y));

   // Flags lag the pointers by one clk; still well inside a strobe period
   always_ff @(posedge clk) begin
      if (clear) begin
         full_flag_n <= 1'b1;
         empty_flag_n <= 1'b0;
         half_level_flag <= 1'b0;
         edge_level_flag <= 1'b1;
      end else begin
         full_flag_n <= ~full;
         empty_flag_n <= ~empty;
         half_level_flag <= (count >= HALF_CNT);
         edge_level_flag <= edge_now;
      end
   end

   // APB slave: data prepared in setup, answered with pready in access
   fifo_flags_t flags_rd;
   assign flags_rd = '{edge_lvl: edge_level_flag, half: half_level_flag,
                       empty_n: empty_flag_n, full_n: full_flag_n};

   logic apb_setup;
   logic apb_access;
   logic addr_hit;
   logic [31:0] rd_mux;
   assign apb_setup = psel & ~penable;
   assign apb_access = psel & penable & pready;

   always_comb begin
      rd_mux = 32'h0000_0000;
      addr_hit = 1'b1;
      unique case (paddr)
         `FIFO_ADDR_STATUS: begin
            rd_mux[AW:0] = count;
            rd_mux[`FIFO_STATUS_FLAGS +: 4] = flags_rd;
            rd_mux[`FIFO_STATUS_STATE +: 2] = state;
         end
         `FIFO_ADDR_CTRL: begin
            rd_mux = 32'h0000_0000;
         end
         `FIFO_ADDR_OFS: begin
            rd_mux[OW-1:0] = ofs_x;
            rd_mux[`FIFO_OFS_NEAR_FULL +: OW] = ofs_y;
         end
         default: begin
            addr_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= apb_setup & ~pready;
         if (apb_setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~addr_hit;
         end
      end
   end

   // Flush is a one-clk pulse that behaves like the reset pin
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flush <= 1'b0;
      end else begin
         flush <= apb_access & pwrite & (paddr == `FIFO_ADDR_CTRL) &
                  pwdata[`FIFO_CTRL_FLUSH];
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_full_no_write: assert property (!clear && full && wr_edge |=> $stable(wr_gray))
      else $error("write pointer moved while full");
   a_empty_no_read: assert property (!clear && empty && rd_edge |=> $stable(rd_gray))
      else $error("read pointer moved while empty");
   a_full_flag_out: assert property (!clear && full |=> !full_flag_n)
      else $error("full flag not low when full");
   a_empty_flag_out: assert property (!clear |=> empty_flag_n == ($past(count) != '0))
      else $error("empty flag wrong for count");
   a_half_flag_out: assert property (!clear
         |=> half_level_flag == ($past(count) >= HALF_CNT))
      else $error("half flag wrong for count");
   a_reset_flag_vals: assert property (clear
         |=> full_flag_n && !empty_flag_n && !half_level_flag)
      else $error("flags wrong after clear");
   a_gray_one_bit: assert property (!clear
         |=> $countones(wr_gray ^ $past(wr_gray)) <= 1)
      else $error("write pointer changed more than one bit");
   a_prog_blocks_wr: assert property (!clear && prog_edge |=> $stable(wr_gray))
      else $error("data written during offset programming");
   a_first_ofs_load: assert property (!clear && prog_edge && state == fifo_prog_x
         |=> ofs_x == $past(din_s[OW-1:0]) && ofs_y == ofs_x)
      else $error("first program edge did not load both offsets");
   a_second_ofs_load: assert property (!clear && prog_edge && state == fifo_prog_y
         |=> $stable(ofs_x) && ofs_y == $past(din_s[OW-1:0]) && state == fifo_run)
      else $error("second program edge wrong");
   a_first_word_out: assert property (!clear && empty && do_write ##1 !clear
         |=> data_out_bus == $past(din_s, 2))
      else $error("first word not on output");
   a_edge_mid_low: assert property (!clear && count > (AW+1)'(ofs_x)
         && count < DEPTH_CNT - (AW+1)'(ofs_y) |=> !edge_level_flag)
      else $error("edge flag high in mid range");

   // Both limits of the edge flag, and the full flag releasing again
   a_full_flag_high: assert property (!clear && !full |=> full_flag_n)
      else $error("full flag low when not full");
   a_edge_low_high: assert property (!clear
         && count <= (AW+1)'(ofs_x) |=> edge_level_flag)
      else $error("edge flag low near empty");
   a_edge_top_high: assert property (!clear
         && count >= DEPTH_CNT - (AW+1)'(ofs_y) |=> edge_level_flag)
      else $error("edge flag low near full");
   a_count_bound: assert property (count <= DEPTH_CNT)
      else $error("word count beyond depth");

   // Each accepted edge moves its pointer by exactly one word
   a_write_step: assert property (!clear && do_write
         |=> wr_bin == $past(wr_bin) + (AW+1)'(1))
      else $error("write pointer did not advance by one");
   a_read_step: assert property (!clear && do_read
         |=> rd_bin == $past(rd_bin) + (AW+1)'(1))
      else $error("read pointer did not advance by one");
   a_word_stored: assert property (do_write
         |=> mem[$past(wr_bin[AW-1:0])] == $past(din_s))
      else $error("written word not in storage");
   a_read_gray_one: assert property (!clear
         |=> $countones(rd_gray ^ $past(rd_gray)) <= 1)
      else $error("read pointer changed more than one bit");
   a_ptr_cleared: assert property (clear |=> wr_bin == '0 && rd_bin == '0)
      else $error("pointers not cleared");
   a_ofs_default: assert property (clear
         |=> ofs_x == `FIFO_OFS_DEFAULT && ofs_y == `FIFO_OFS_DEFAULT)
      else $error("offsets not back at default");
   a_prog_ends: assert property (!clear && wr_edge && !prog_low
         |=> state == fifo_run)
      else $error("plain write did not end programming");
   a_drive_follows: assert property (!sys_rst
         |=> data_out_drive == !$past(pins_s.oe_n))
      else $error("output drive does not follow enable pin");

   c_reach_full: cover property (full && wr_edge);
   c_coincident: cover property (wr_edge && rd_edge && !empty && !full);
   c_second_prog: cover property (prog_edge && state == fifo_prog_y);
   c_apb_flush: cover property (flush);
   c_out_disabled: cover property (!data_out_drive);

endmodule // fifo_buf_top

`default_nettype wire

/* verilog/fifo_pkg.sv */
// Types shared by the strobed buffer.
// Assumes fifo_regs.svh is on the include path.
`include "fifo_regs.svh"

package fifo_pkg;

   typedef enum logic [1:0] {
      fifo_prog_x,
      fifo_prog_y,
      fifo_run
   } fifo_state_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic prog_n;
      logic rst_n;
      logic oe_n;
   } fifo_pins_t;

   typedef struct packed {
      logic edge_lvl;
      logic half;
      logic empty_n;
      logic full_n;
   } fifo_flags_t;

endpackage

/* verilog/fifo_regs.svh */
// Constants of the 256 x 18 strobed buffer: geometry, offsets, register map.
// Assumes it is included by fifo_pkg.sv and fifo_buf_top.sv only.
// Behaviour
// - Storage holds 256 words of 18 bits.
// - Write and read strobes may be unrelated or coincident.
// - Each rising write strobe stores the input bus word.
// - Each rising read strobe advances to the next word, in write order.
// - Full when words written exceed words read by 256.
// - Write strobes while full change nothing.
// - Read strobes while empty change nothing.
// - Full flag low while full, high otherwise.
// - Empty flag low while empty, high otherwise.
// - Half level flag high at 128 or more words, low below.
// - First one or two write edges after reset may load the offsets.
// - Edge flag high at count up to near-empty or from 256 minus near-full.
// - Edge flag low for counts between those two limits.
// - Reset clears pointers, full flag high, half and empty flags low.
// - First word into empty buffer raises empty flag and shows on output.
// - Output equals stored bits; output disabled while drive enable pin high.
// - First write edge with program enable low loads bits 0-6 into both offsets.
// - Second such edge reloads only the near-full offset.
// - Offsets up to 127; data writes blocked while programming.
// - Program enable held high leaves both offsets at 32.
`ifndef FIFO_REGS_SVH
`define FIFO_REGS_SVH

`define FIFO_DEPTH 256
`define FIFO_WIDTH 18
`define FIFO_OFS_W 7
`define FIFO_OFS_DEFAULT 7'h20

`define FIFO_ADDR_STATUS 12'h000
`define FIFO_ADDR_CTRL 12'h004
`define FIFO_ADDR_OFS 12'h008

`define FIFO_CTRL_FLUSH 0
`define FIFO_STATUS_FLAGS 16
`define FIFO_STATUS_STATE 20
`define FIFO_OFS_NEAR_FULL 8

`endif
